// ### hdl/sdp_serial_port.v
`include "sdp_consts.vh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - modulator samples on both converter clock phases
// - serial mode two clocks after strobes seen low
// - result_ready rises when new word is ready
// - result_ready low during sync or calibration
// - frame start shifts sixteen bits, MSB first
// - bits change on sclk rise, valid on fall
// - frame_sync_n high keeps serial_out undriven
// - converter drives its clock on sclk
// - sync rising edge restarts filter and timing
// - range_select low unipolar, high bipolar
// - low_power_req high enters standby
// - result_valid pin is data-valid output only
// - result_ready rises at most once every 32 converter clocks
module sdp_serial_port (
    input wire mclk,
    input wire resetn,
    input wire conv_clk,
    input wire cs_n,
    input wire rd_n,
    input wire wr_n,
    input wire frame_sync_n,
    input wire sync_in,
    input wire cal_in,
    input wire range_select,
    input wire low_power_req,
    input wire [15:0] sample_data,
    input wire sample_valid,
    output wire sample_ready,
    output reg sclk_out,
    output reg serial_out,
    output reg serial_oe,
    output reg result_ready,
    output reg result_valid,
    output reg serial_mode,
    output reg standby,
    output reg sample_phase
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

wire [`SDP_PIN_COUNT-1:0] pins_raw;
wire [`SDP_PIN_COUNT-1:0] pins;

assign pins_raw = {low_power_req, range_select, cal_in, sync_in, frame_sync_n,
                   wr_n, rd_n, cs_n, conv_clk};

sdp_sync #(
    .W(`SDP_PIN_COUNT)
) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .async_in(pins_raw),
    .sync_out(pins)
);

wire ck_s;
wire fs_n_s;
wire strobes_low;

assign ck_s = pins[`SDP_PIN_CLK];
assign fs_n_s = pins[`SDP_PIN_FS];
assign strobes_low = !pins[`SDP_PIN_CS] && !pins[`SDP_PIN_RD] && !pins[`SDP_PIN_WR];

////////////////////////////////////////////////////////////////////////////////
// converter clock edges

reg ck_prev_reg;
wire ck_rise;
wire ck_fall;

// edges are lost if conv_clk runs faster than half of mclk
assign ck_rise = ck_s && !ck_prev_reg;
assign ck_fall = !ck_s && ck_prev_reg;

always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        ck_prev_reg <= 1'b0;
    end else begin
        ck_prev_reg <= ck_s;
    end
end

////////////////////////////////////////////////////////////////////////////////
// word fifo between the filter and the output register

wire [15:0] fifo_data;
wire fifo_valid;
reg fifo_take;

// a full fifo refuses words; the filter side must hold them
sdp_fifo #(
    .WIDTH(`SDP_WORD_BITS),
    .DEPTH(`SDP_FIFO_DEPTH),
    .AW(`SDP_FIFO_AW)
) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
);

// bipolar words leave in offset binary, unipolar as straight binary
function [15:0] code_word;
    input [15:0] raw;
    input bipolar;
    begin
        code_word = bipolar ? {~raw[15], raw[14:0]} : raw;
    end
endfunction

// one place to move the output word up by a bit
function [15:0] shift_up;
    input [15:0] value;
    begin
        shift_up = {value[14:0], 1'b0};
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// power-up strap and mode

// binary mode codes
localparam [1:0] MODE_STRAP = 2'h0;
localparam [1:0] MODE_SERIAL = 2'h1;
localparam [1:0] MODE_OTHER = 2'h2;

reg [1:0] mode_reg;
reg [1:0] strap_cnt_reg;

// a reset in mid-run repeats the strap with whatever the strobes show
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        mode_reg <= MODE_STRAP;
        strap_cnt_reg <= 2'h0;
        serial_mode <= 1'b0;
    end else begin
        case (mode_reg)
            MODE_STRAP: begin
                if (!strobes_low) begin
                    // the parallel port is not built here; the block stays idle
                    mode_reg <= MODE_OTHER;
                end else if (ck_rise) begin
                    if (strap_cnt_reg == `SDP_STRAP_CYCLES - 2'h1) begin
                        mode_reg <= MODE_SERIAL;
                        serial_mode <= 1'b1;
                    end
                    strap_cnt_reg <= strap_cnt_reg + 2'h1;
                end
            end
            MODE_SERIAL: begin
                // strobes are not watched again; the host keeps them low
                mode_reg <= MODE_SERIAL;
            end
            MODE_OTHER: begin
                mode_reg <= MODE_OTHER;
            end
            default: begin
                mode_reg <= MODE_STRAP;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// conversion timing, sync, calibration and standby

reg [4:0] word_cnt_reg;
reg [11:0] busy_cnt_reg;
reg sync_prev_reg;
reg [15:0] shift_reg;
reg [4:0] bits_left_reg;
wire active;
wire sync_edge;
wire cal_req;
wire busy;
wire word_due;

assign active = serial_mode && !standby;
// sync is sampled once per converter clock, so a low held one clock is seen
assign sync_edge = pins[`SDP_PIN_SYNC] && !sync_prev_reg;
assign cal_req = pins[`SDP_PIN_CAL];
assign busy = busy_cnt_reg != 12'h000;
assign word_due = word_cnt_reg == `SDP_WORD_LAST;

always @* begin
    fifo_take = active && ck_rise && word_due && !busy && fifo_valid;
end

always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        word_cnt_reg <= 5'h00;
        busy_cnt_reg <= 12'h000;
        sync_prev_reg <= 1'b1;
        standby <= 1'b0;
        result_ready <= 1'b0;
        result_valid <= 1'b0;
        sample_phase <= 1'b0;
        shift_reg <= 16'h0000;
    end else begin
        if (serial_mode && ck_rise) begin
            sync_prev_reg <= pins[`SDP_PIN_SYNC];
            standby <= pins[`SDP_PIN_LP];
        end
        // one modulator sample on each converter clock edge
        if (active && (ck_rise || ck_fall)) begin
            sample_phase <= ck_s;
        end
        if (!active) begin
            word_cnt_reg <= 5'h00;
            // leaving standby settles the filter like a sync
            busy_cnt_reg <= `SDP_SETTLE_CYCLES;
            result_ready <= 1'b0;
            result_valid <= 1'b0;
        end else if (ck_rise) begin
            if (cal_req) begin
                busy_cnt_reg <= `SDP_CAL_CYCLES;
                word_cnt_reg <= 5'h00;
                result_ready <= 1'b0;
                result_valid <= 1'b0;
            end else if (sync_edge) begin
                busy_cnt_reg <= `SDP_SETTLE_CYCLES;
                word_cnt_reg <= 5'h00;
                result_ready <= 1'b0;
                result_valid <= 1'b0;
            end else begin
                word_cnt_reg <= word_cnt_reg + 5'h01;
                if (busy) begin
                    busy_cnt_reg <= busy_cnt_reg - 12'h001;
                    result_ready <= 1'b0;
                end else if (word_due && fifo_valid) begin
                    shift_reg <= code_word(fifo_data, pins[`SDP_PIN_RANGE]);
                    result_ready <= 1'b1;
                    result_valid <= 1'b1;
                end else begin
                    // high for one converter clock only
                    result_ready <= 1'b0;
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// serial output

reg framed_reg;
reg [15:0] out_word_reg;

always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        framed_reg <= 1'b0;
        out_word_reg <= 16'h0000;
        bits_left_reg <= 5'h00;
        serial_out <= 1'b0;
        serial_oe <= 1'b0;
        sclk_out <= 1'b0;
    end else begin
        // sclk runs free while active; the host frames with frame_sync_n
        sclk_out <= active && ck_s;
        if (!active || fs_n_s) begin
            framed_reg <= 1'b0;
            serial_oe <= 1'b0;
            serial_out <= 1'b0;
        end else if (!framed_reg) begin
            // frame opens: MSB is driven at once
            framed_reg <= 1'b1;
            serial_oe <= 1'b1;
            serial_out <= shift_reg[15];
            out_word_reg <= shift_up(shift_reg);
            bits_left_reg <= 5'h0F;
        end else if (ck_rise && bits_left_reg != 5'h00) begin
            // next bit on the sclk rise, stable through the fall
            serial_out <= out_word_reg[15];
            out_word_reg <= shift_up(out_word_reg);
            bits_left_reg <= bits_left_reg - 5'h01;
        end else if (ck_rise) begin
            // word done; the line idles low until the frame closes
            serial_out <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// ### hdl/sdp_consts.vh
`ifndef SDP_CONSTS_VH
`define SDP_CONSTS_VH

// word and fifo shape
`define SDP_WORD_BITS 16
`define SDP_FIFO_DEPTH 16
`define SDP_FIFO_AW 4

// timing, in converter clock periods
`define SDP_WORD_PERIOD 32
`define SDP_WORD_LAST 5'h1F
`define SDP_STRAP_CYCLES 2'h2
`define SDP_SETTLE_CYCLES 12'h5B0
`define SDP_CAL_CYCLES 12'hB60

// synchroniser vector bit positions
`define SDP_PIN_CLK 0
`define SDP_PIN_CS 1
`define SDP_PIN_RD 2
`define SDP_PIN_WR 3
`define SDP_PIN_FS 4
`define SDP_PIN_SYNC 5
`define SDP_PIN_CAL 6
`define SDP_PIN_RANGE 7
`define SDP_PIN_LP 8
`define SDP_PIN_COUNT 9

`endif

// ### hdl/sdp_sync.v
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser; the first stage feeds only the second
module sdp_sync #(
    parameter W = 1
) (
    input wire mclk,
    input wire resetn,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);

reg [W-1:0] meta_reg;

always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        meta_reg <= {W{1'b0}};
        sync_out <= {W{1'b0}};
    end else begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end
end

endmodule
`default_nettype wire

// ### hdl/sdp_fifo.v
`timescale 1ns/1ps
`default_nettype none

// small fifo; read data leave from a register
module sdp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire mclk,
    input wire resetn,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output reg in_ready,
    output reg [WIDTH-1:0] out_data,
    output reg out_valid,
    input wire out_ready
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr_reg;
reg [AW-1:0] rd_ptr_reg;
reg [AW:0] count_reg;
reg [AW:0] count_next;
wire push;
wire pop;

assign push = in_valid && in_ready;
// refill the output register when it is empty or being taken
assign pop = (count_reg != {(AW+1){1'b0}}) && (!out_valid || out_ready);

always @* begin
    count_next = count_reg;
    if (push && !pop) begin
        count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
        count_next = count_reg - 1'b1;
    end
end

always @(posedge mclk) begin
    if (push) begin
        mem[wr_ptr_reg] <= in_data;
    end
end

always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg <= {(AW+1){1'b0}};
        in_ready <= 1'b1;
        out_data <= {WIDTH{1'b0}};
        out_valid <= 1'b0;
    end else begin
        count_reg <= count_next;
        in_ready <= (count_next != DEPTH[AW:0]);
        if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            out_data <= mem[rd_ptr_reg];
            out_valid <= 1'b1;
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// ### testbench/sdp_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sdp_port_monitor (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic frame_sync_n,
    input wire logic sync_in,
    input wire logic low_power_req,
    input wire logic sclk_out,
    input wire logic serial_out,
    input wire logic serial_oe,
    input wire logic result_ready,
    input wire logic result_valid,
    input wire logic serial_mode,
    input wire logic standby,
    input wire logic sample_phase
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    logic rr_d;
    logic [8:0] gap;
    ////////////////////////////////////////
    // gap saturates, so refused slots and settles are not measured
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rr_d <= 1'b0;
            gap <= 9'h1FF;
        end else begin
            rr_d <= result_ready;
            if (result_ready && !rr_d)
                gap <= 9'h000;
            else if (gap != 9'h1FF)
                gap <= gap + 9'h001;
        end
    end
    ////////////////////////////////////////
    a_fs_release: assert property (frame_sync_n [*3] |=> !serial_oe)
        else $error("serial_oe high with frame sync idle");
    a_idle_strap: assert property (!serial_mode
        |-> !sclk_out && !serial_oe && !result_ready)
        else $error("port active before serial mode");
    a_ready_valid: assert property (result_ready |-> result_valid)
        else $error("result_ready without result_valid");
    a_ready_width: assert property ($rose(result_ready)
        |-> result_ready [*8] ##1 !result_ready)
        else $error("result_ready pulse width wrong");
    a_ready_gap: assert property ($rose(result_ready) && gap < 9'h12C |-> gap == 9'h0FF)
        else $error("result_ready spacing wrong");
    a_sync_clear: assert property ($rose(sync_in) |-> ##[1:16] !result_valid)
        else $error("sync did not clear result_valid");
    a_standby_entry: assert property ($rose(low_power_req) && serial_mode
        |-> ##[1:14] standby)
        else $error("standby not entered");
    a_bit_stable: assert property ($fell(sclk_out) && serial_oe && $past(serial_oe)
        |-> $stable(serial_out))
        else $error("serial_out moved at sclk fall");
    a_phase_both: assert property (serial_mode && !standby && $changed(sample_phase)
        |-> ##4 ($changed(sample_phase) || standby))
        else $error("sample_phase missed a converter clock phase");
endmodule
bind sdp_serial_port sdp_port_monitor u_mon (
    .mclk(mclk), .resetn(resetn), .frame_sync_n(frame_sync_n), .sync_in(sync_in),
    .low_power_req(low_power_req), .sclk_out(sclk_out), .serial_out(serial_out),
    .serial_oe(serial_oe), .result_ready(result_ready), .result_valid(result_valid),
    .serial_mode(serial_mode), .standby(standby), .sample_phase(sample_phase)
);
`default_nettype wire

// ### testbench/sdp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdp_host_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sclk_out,
    input wire logic serial_out,
    input wire logic serial_oe,
    input wire logic result_ready,
    output logic frame_sync_n,
    output var logic [15:0] rx_word,
    output var logic rx_done
);
    logic open_reg, sclk_d;
    logic [4:0] nbits;
    logic [15:0] shreg;
    wire logic line_val;
    // released line shows the inverse of the last bit, never a lucky match
    assign line_val = serial_oe ? serial_out : ~shreg[0];
    assign frame_sync_n = !(result_ready || open_reg);
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            open_reg <= 1'b0;
            sclk_d <= 1'b0;
            nbits <= 5'h00;
            shreg <= 16'h0000;
            rx_word <= 16'h0000;
            rx_done <= 1'b0;
        end else begin
            sclk_d <= sclk_out;
            rx_done <= 1'b0;
            if (result_ready)
                open_reg <= 1'b1;
            if (open_reg && sclk_d && !sclk_out) begin
                shreg <= {shreg[14:0], line_val};
                nbits <= nbits + 5'h01;
                if (nbits == 5'h0F) begin
                    rx_word <= {shreg[14:0], line_val};
                    rx_done <= 1'b1;
                    open_reg <= 1'b0;
                    nbits <= 5'h00;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/sdp_serial_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module sdp_serial_port_test;
    logic mclk = 1'b0, conv_clk = 1'b0, resetn = 1'b0, sync_in = 1'b0, cal_in = 1'b0;
    logic range_select = 1'b0, low_power_req = 1'b0, sample_valid = 1'b0, strap_n = 1'b0;
    logic [15:0] sample_data = 16'h0000;
    wire logic frame_sync_n, sample_ready, sclk_out, serial_out, serial_oe, result_ready;
    wire logic result_valid, serial_mode, standby, sample_phase, rx_done;
    wire logic [15:0] rx_word;
    int bad_count = 0, total_checks = 0, n, cyc;
    logic [15:0] row_data [4] = '{16'h8001, 16'h8001, 16'h7FFE, 16'hA5C3};
    logic row_range [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [15:0] row_exp [4] = '{16'h8001, 16'h0001, 16'hFFFE, 16'hA5C3};
    always #12.5 mclk = ~mclk;
    always #100 conv_clk = ~conv_clk;
    // no test-mode pin is a port here; the bench keeps them grounded
    sdp_serial_port uut (
        .mclk(mclk), .resetn(resetn), .conv_clk(conv_clk),
        .cs_n(strap_n), .rd_n(1'b0), .wr_n(1'b0),
        .frame_sync_n(frame_sync_n), .sync_in(sync_in), .cal_in(cal_in),
        .range_select(range_select), .low_power_req(low_power_req),
        .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sclk_out(sclk_out), .serial_out(serial_out), .serial_oe(serial_oe),
        .result_ready(result_ready), .result_valid(result_valid),
        .serial_mode(serial_mode), .standby(standby), .sample_phase(sample_phase)
    );
    sdp_host_model hm (
        .mclk(mclk), .resetn(resetn), .sclk_out(sclk_out), .serial_out(serial_out),
        .serial_oe(serial_oe), .result_ready(result_ready), .frame_sync_n(frame_sync_n),
        .rx_word(rx_word), .rx_done(rx_done)
    );
    ////////////////////////////////////////
    function automatic logic [15:0] word_at(input int i, input logic want);
        if (i < 4)
            return want ? row_exp[i] : row_data[i];
        return {i[3:0], 12'h0A5};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_word(input int lim);
        cyc = 0;
        do begin
            @(posedge mclk);
            cyc++;
        end while (rx_done !== 1'b1 && cyc < lim);
        check(16'(rx_done), 16'h0001, "word arrival");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #2000000;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge mclk);
        check(16'(sample_ready), 16'h0001, "ready in reset");
        check(16'(serial_oe), 16'h0000, "oe in reset");
        resetn <= 1'b1;
        @(posedge mclk);
        check(16'(serial_mode), 16'h0000, "mode at release");
        repeat (40) @(posedge mclk);
        check(16'(serial_mode), 16'h0001, "mode after strap");
        $display("test reset done");
        // settle keeps the reader idle, so the buffer fills until it refuses
        sample_valid <= 1'b1;
        sample_data <= word_at(0, 1'b0);
        n = 0;
        repeat (40) begin
            @(posedge mclk);
            if (sample_ready === 1'b1) begin
                n++;
                sample_data <= word_at(n, 1'b0);
            end
        end
        sample_valid <= 1'b0;
        check(n[15:0], 16'h0011, "words taken");
        check(16'(sample_ready), 16'h0000, "ready when full");
        $display("test fill done");
        for (int i = 0; i < 17; i++) begin
            range_select <= (i < 4) ? row_range[i] : 1'b0;
            wait_word(13000);
            check(rx_word, word_at(i, 1'b1), "serial word");
            if (i > 0)
                check(cyc[15:0], 16'h0100, "word spacing");
            check(16'(result_valid), 16'h0001, "valid with data");
        end
        check(16'(sample_ready), 16'h0001, "ready after drain");
        $display("test stream done");
        sync_in <= 1'b1;
        repeat (16) @(posedge mclk);
        sync_in <= 1'b0;
        check(16'(result_valid), 16'h0000, "valid in sync");
        check(16'(result_ready), 16'h0000, "ready in sync");
        sample_valid <= 1'b1;
        sample_data <= 16'h3C5A;
        @(posedge mclk);
        sample_valid <= 1'b0;
        wait_word(12500);
        check(rx_word, 16'h3C5A, "word after sync");
        check(16'(cyc > 11500 && cyc < 12200), 16'h0001, "sync settle");
        $display("test sync done");
        cal_in <= 1'b1;
        repeat (16) @(posedge mclk);
        cal_in <= 1'b0;
        check(16'(result_valid), 16'h0000, "valid in cal");
        low_power_req <= 1'b1;
        repeat (16) @(posedge mclk);
        check(16'(standby), 16'h0001, "standby on");
        low_power_req <= 1'b0;
        repeat (16) @(posedge mclk);
        check(16'(standby), 16'h0000, "standby off");
        $display("test cal and standby done");
        // a second reset with one strobe high must leave the port idle
        strap_n <= 1'b1;
        resetn <= 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        check(16'(serial_oe), 16'h0000, "oe at release");
        repeat (40) @(posedge mclk);
        check(16'(serial_mode), 16'h0000, "mode with strobe high");
        check(16'(sclk_out), 16'h0000, "sclk with strobe high");
        check(16'(result_ready), 16'h0000, "ready with strobe high");
        $display("test strap done");
        conclude();
    end
endmodule
`default_nettype wire
